// >>> include/rfd_pkg.sv
/*
 Shared constants and types for the receive-flush and DMA-enable control block.
 Assumes one 100 MHz clock with synchronous active-high reset; the serial side is
 paced by an enable pulse from a divider rather than by its own clock.
*/
// Functional notes
// - Writing one to the receive-flush bit empties the receive FIFO and idles the receive FSM.
// - A receive flush leaves every configuration bit untouched and resets only FIFO and FSM.
// - The flush is carried between the system side and the serial side by a toggle handshake.
// - Flush completion shows only after both sides have finished, several cycles later.
// - The hardware clears the receive-flush bit itself when the flush has completed.
// - The DMA transmit enable holds the transmit DMA side idle at zero and running at one.
// - An end-of-transfer from the DMA on the transmit side clears the DMA transmit enable.
// - The DMA receive enable holds the receive DMA side idle at zero and running at one.
// - An end-of-transfer from the DMA on the receive side clears the DMA receive enable.
// - Clearing the peripheral enable resets the receive path, handshake and DMA sides; the pace divider keeps running.
package rfd_pkg;

    // control word; bit positions follow the struct layout
    localparam int CTRL_W = 16;
    localparam int ENABLE_BIT = 0;
    localparam int FLUSH_BIT = 8;
    localparam int DMA_TX_BIT = 9;
    localparam int DMA_RX_BIT = 10;

    typedef struct packed {
        logic [4:0] rsvd_hi;
        logic dma_rx_en;
        logic dma_tx_en;
        logic receive_flush;
        logic [6:0] other;
        logic peripheral_enable;
    } rfd_ctrl_t;

    localparam rfd_ctrl_t CTRL_RESET = rfd_ctrl_t'(16'h0000);

    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int SER_DIV_DEF = 4;
    localparam int DIV_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
    localparam logic [BIT_CNT_W-1:0] FIRST_BIT = 3'h1;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } rfd_byte_t;

    typedef enum {RX_IDLE, RX_SHIFT} rfd_rx_state_t;

endpackage

// >>> core/rfd_rx_fifo.sv
/*
 Receive FIFO with a synchronous flush that empties it in one cycle.
 Assumes the caller never pushes when full or pops when empty; such requests are ignored.
*/
`timescale 1ns/1ps
module rfd_rx_fifo import rfd_pkg::*; #(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic empty,
    output logic full
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic do_push, do_pop;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    assign head = mem_q[rd_q[AW-1:0]];

    always_comb begin
        do_push = push && !full && !flush;
        do_pop = pop && !empty && !flush;
        wr_d = wr_q;
        rd_d = rd_q;
        if (flush) begin
            // flush discards contents by aligning pointers
            rd_d = wr_q;
        end else begin
            if (do_push) begin
                wr_d = wr_q + (AW+1)'(1);
            end
            if (do_pop) begin
                rd_d = rd_q + (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_q[AW-1:0]] <= push_data;
        end
    end
endmodule

// >>> core/rfd_rx_flush_dma.sv
/*
 Receive flush, receive byte assembly and DMA enable control of a two-wire controller.
 Assumes control words arrive as write strobes, serial bits arrive with a valid flag, and the
 DMA controller gives one-cycle end-of-transfer pulses.
*/
`timescale 1ns/1ps
module rfd_rx_flush_dma import rfd_pkg::*; #(
    parameter int SER_DIV = SER_DIV_DEF,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ctrl_we,
    input wire rfd_ctrl_t ctrl_wdata,
    output rfd_ctrl_t ctrl_rdata,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_pop,
    output logic [DATA_W-1:0] rx_data,
    output logic rx_avail,
    input wire logic dma_rx_ack,
    input wire logic dma_rx_eot,
    input wire logic dma_tx_eot,
    input wire logic tx_fifo_ready,
    output logic dma_rx_req,
    output logic dma_tx_req
);
    localparam int FLUSH_MAX = 2 * SER_DIV + 8;

    rfd_ctrl_t ctrl_q, ctrl_d;
    logic soft_rst, flush_start, flush_done;

    // divider for the serial-side pace
    logic [DIV_W-1:0] div_q, div_d;
    logic ser_en_q, ser_en_d;

    // toggle handshake registers
    logic req_tgl_q, req_tgl_d;
    logic req_sync1_q, req_sync2_q;
    logic ser_seen_q, ser_seen_d, ack_tgl_q, ack_tgl_d;
    logic ack_sync1_q, ack_sync2_q;
    logic ser_flush;

    // receive fsm
    rfd_rx_state_t rx_state_q, rx_state_d;
    logic [BIT_CNT_W-1:0] rx_cnt_q, rx_cnt_d;
    logic [DATA_W-1:0] shift_q, shift_d;
    rfd_byte_t push_b;

    // fifo and outputs
    logic fifo_flush, fifo_pop, fifo_empty;
    logic [DATA_W-1:0] fifo_head;
    logic [DATA_W-1:0] rx_data_q;
    logic rx_avail_q, dma_rx_req_q, dma_tx_req_q;

    // global enable low holds everything except the pace divider in reset
    assign soft_rst = srst || !ctrl_q.peripheral_enable;

    always_comb begin
        div_d = div_q + DIV_W'(1);
        ser_en_d = 1'b0;
        if (div_q == DIV_W'(SER_DIV - 1)) begin
            div_d = '0;
            ser_en_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_q <= '0;
            ser_en_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ser_en_q <= ser_en_d;
        end
    end

    // done only once the serial side has echoed the current request
    assign flush_done = ctrl_q.receive_flush && (ack_sync2_q == req_tgl_q);

    always_comb begin
        ctrl_d = ctrl_q;
        flush_start = 1'b0;
        if (ctrl_we) begin
            ctrl_d.peripheral_enable = ctrl_wdata.peripheral_enable;
            ctrl_d.dma_tx_en = ctrl_wdata.dma_tx_en;
            ctrl_d.dma_rx_en = ctrl_wdata.dma_rx_en;
            // a zero written to the flush bit cannot cancel a flush
            if (ctrl_wdata.receive_flush && !ctrl_q.receive_flush) begin
                ctrl_d.receive_flush = 1'b1;
                flush_start = 1'b1;
            end
        end
        if (flush_done) begin
            ctrl_d.receive_flush = 1'b0;
        end
        // the end-of-transfer event beats a same-cycle software write
        if (dma_tx_eot) begin
            ctrl_d.dma_tx_en = 1'b0;
        end
        if (dma_rx_eot) begin
            ctrl_d.dma_rx_en = 1'b0;
        end
        if (!ctrl_q.peripheral_enable) begin
            ctrl_d.dma_tx_en = 1'b0;
            ctrl_d.dma_rx_en = 1'b0;
            ctrl_d.receive_flush = 1'b0;
            flush_start = 1'b0;
        end
        ctrl_d.other = '0;
        ctrl_d.rsvd_hi = '0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign ctrl_rdata = ctrl_q;

    // system side request toggle and acknowledge synchroniser
    always_comb begin
        req_tgl_d = req_tgl_q ^ flush_start;
    end

    always_ff @(posedge clk) begin
        if (soft_rst) begin
            req_tgl_q <= 1'b0;
            ack_sync1_q <= 1'b0;
            ack_sync2_q <= 1'b0;
        end else begin
            req_tgl_q <= req_tgl_d;
            ack_sync1_q <= ack_tgl_q;
            ack_sync2_q <= ack_sync1_q;
        end
    end

    // serial side: picks the request up only on its own pace
    assign ser_flush = ser_en_q && (req_sync2_q != ser_seen_q);

    always_comb begin
        ser_seen_d = ser_seen_q;
        ack_tgl_d = ack_tgl_q;
        if (ser_flush) begin
            ser_seen_d = req_sync2_q;
            ack_tgl_d = req_sync2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (soft_rst) begin
            req_sync1_q <= 1'b0;
            req_sync2_q <= 1'b0;
            ser_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
        end else begin
            req_sync1_q <= req_tgl_q;
            req_sync2_q <= req_sync1_q;
            ser_seen_q <= ser_seen_d;
            ack_tgl_q <= ack_tgl_d;
        end
    end

    // byte assembly, msb first; bits seen while a flush is pending are dropped
    always_comb begin
        rx_state_d = rx_state_q;
        rx_cnt_d = rx_cnt_q;
        shift_d = shift_q;
        push_b = '{valid: 1'b0, data: {shift_q[DATA_W-2:0], rx_bit}};
        if (ser_flush) begin
            rx_state_d = RX_IDLE;
            rx_cnt_d = '0;
        end else if (ser_en_q && rx_bit_valid && !ctrl_q.receive_flush) begin
            shift_d = {shift_q[DATA_W-2:0], rx_bit};
            case (rx_state_q)
                RX_IDLE: begin
                    rx_state_d = RX_SHIFT;
                    rx_cnt_d = FIRST_BIT;
                end
                RX_SHIFT: begin
                    if (rx_cnt_q == LAST_BIT) begin
                        push_b.valid = 1'b1;
                        rx_state_d = RX_IDLE;
                        rx_cnt_d = '0;
                    end else begin
                        rx_cnt_d = rx_cnt_q + BIT_CNT_W'(1);
                    end
                end
                default: begin
                    rx_state_d = RX_IDLE;
                    rx_cnt_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (soft_rst) begin
            rx_state_q <= RX_IDLE;
            rx_cnt_q <= '0;
            shift_q <= '0;
        end else begin
            rx_state_q <= rx_state_d;
            rx_cnt_q <= rx_cnt_d;
            shift_q <= shift_d;
        end
    end

    // configuration is not reset by a flush, only the fifo and the receive fsm
    assign fifo_flush = soft_rst || ctrl_q.receive_flush;
    // pops are ignored during a flush
    assign fifo_pop = (rx_pop || dma_rx_ack) && rx_avail_q && !ctrl_q.receive_flush;

    rfd_rx_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .flush(fifo_flush),
        .push(push_b.valid),
        .push_data(push_b.data),
        .pop(fifo_pop),
        .head(fifo_head),
        .empty(fifo_empty),
        .full()
    );

    always_ff @(posedge clk) begin
        if (soft_rst) begin
            rx_data_q <= '0;
            rx_avail_q <= 1'b0;
            dma_rx_req_q <= 1'b0;
            dma_tx_req_q <= 1'b0;
        end else begin
            rx_data_q <= fifo_head;
            rx_avail_q <= !fifo_empty && !fifo_pop && !ctrl_q.receive_flush;
            // requests follow enable and fifo state
            dma_rx_req_q <= ctrl_q.dma_rx_en && !fifo_empty && !fifo_pop
                && !ctrl_q.receive_flush;
            dma_tx_req_q <= ctrl_q.dma_tx_en && tx_fifo_ready;
        end
    end

    assign rx_data = rx_data_q;
    assign rx_avail = rx_avail_q;
    assign dma_rx_req = dma_rx_req_q;
    assign dma_tx_req = dma_tx_req_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_flush_self_clear: assert property (
        $rose(ctrl_q.receive_flush) |-> ##[2:FLUSH_MAX] !ctrl_q.receive_flush)
        else $error("receive flush bit not cleared in time");
    a_flush_not_early: assert property (
        $rose(ctrl_q.receive_flush) && ctrl_q.peripheral_enable |-> ctrl_q.receive_flush[*5])
        else $error("receive flush completed too early");
    a_flush_fifo_empty: assert property (
        $fell(ctrl_q.receive_flush) && ctrl_q.peripheral_enable |-> fifo_empty)
        else $error("fifo not empty after flush");
    a_flush_fsm_idle: assert property (
        ser_flush && ctrl_q.peripheral_enable |=> rx_state_q == RX_IDLE && rx_cnt_q == '0)
        else $error("receive fsm not idle after flush");
    a_flush_keeps_cfg: assert property (
        ctrl_q.receive_flush && !ctrl_we && !dma_tx_eot && !dma_rx_eot
        |=> $stable(ctrl_q.dma_tx_en) && $stable(ctrl_q.dma_rx_en))
        else $error("flush changed configuration");
    a_tx_eot_clear: assert property (
        dma_tx_eot |=> !ctrl_q.dma_tx_en ##1 !dma_tx_req_q)
        else $error("tx enable survived end of transfer");
    a_rx_eot_clear: assert property (
        dma_rx_eot |=> !ctrl_q.dma_rx_en ##1 !dma_rx_req_q)
        else $error("rx enable survived end of transfer");
    a_tx_idle_off: assert property (
        !ctrl_q.dma_tx_en |=> !dma_tx_req_q)
        else $error("tx request while disabled");
    a_rx_req_cause: assert property (
        dma_rx_req_q |-> $past(ctrl_q.dma_rx_en) && !$past(fifo_empty))
        else $error("rx request without enable or data");
    a_pe_off_reset: assert property (
        !ctrl_q.peripheral_enable |=> !ctrl_q.dma_tx_en && !ctrl_q.dma_rx_en
        && !ctrl_q.receive_flush && fifo_empty)
        else $error("peripheral disable did not reset");
endmodule

// >>> verification/rfd_dma_model.sv
/*
 Behavioural DMA controller facing the receive-flush and DMA-enable block.
 Assumes one clock and reset shared with the block; acks one byte per request and
 signals end of transfer after a fixed count.
*/
`timescale 1ns/1ps
module rfd_dma_model import rfd_pkg::*; #(
    parameter int RX_N = 2,
    parameter int TX_N = 5
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic dma_rx_req,
    input wire logic dma_tx_req,
    output logic dma_rx_ack,
    output logic dma_rx_eot,
    output logic dma_tx_eot
);
    int rx_cnt;
    int tx_cnt;

    always @(posedge clk) begin
        if (srst) begin
            dma_rx_ack <= 1'b0;
            dma_rx_eot <= 1'b0;
            dma_tx_eot <= 1'b0;
            rx_cnt <= 0;
            tx_cnt <= 0;
        end else begin
            // ack only on a live request, never two edges running
            dma_rx_ack <= dma_rx_req && !dma_rx_ack && rx_cnt < RX_N;
            if (dma_rx_eot) begin
                rx_cnt <= 0;
            end else if (dma_rx_ack) begin
                rx_cnt <= rx_cnt + 1;
            end
            dma_rx_eot <= rx_cnt == RX_N && !dma_rx_eot;
            if (dma_tx_eot) begin
                tx_cnt <= 0;
            end else if (dma_tx_req && tx_cnt < TX_N) begin
                tx_cnt <= tx_cnt + 1;
            end
            dma_tx_eot <= tx_cnt == TX_N && !dma_tx_eot;
        end
    end
endmodule

// >>> verification/tb.sv
/*
 Self-checking bench for the receive-flush and DMA-enable block.
 Assumes the DMA model file is compiled first; serial bits are held SDIV cycles each.
*/
`timescale 1ns/1ps
module tb import rfd_pkg::*;;
    localparam int SDIV = 4;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ctrl_we = 1'b0;
    logic rx_bit_valid = 1'b0;
    logic rx_bit = 1'b0;
    logic rx_pop = 1'b0;
    logic tx_fifo_ready = 1'b0;
    rfd_ctrl_t ctrl_wdata = CTRL_RESET;
    rfd_ctrl_t ctrl_rdata;
    logic [DATA_W-1:0] rx_data;
    logic rx_avail;
    logic dma_rx_ack;
    logic dma_rx_eot;
    logic dma_tx_eot;
    logic dma_rx_req;
    logic dma_tx_req;
    int n_errors = 0;
    int comparisons = 0;

    always #5 clk = ~clk;

    rfd_rx_flush_dma #(.SER_DIV(SDIV), .DEPTH(8)) u_dut (.clk(clk), .srst(srst),
        .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_pop(rx_pop), .rx_data(rx_data),
        .rx_avail(rx_avail), .dma_rx_ack(dma_rx_ack), .dma_rx_eot(dma_rx_eot),
        .dma_tx_eot(dma_tx_eot), .tx_fifo_ready(tx_fifo_ready), .dma_rx_req(dma_rx_req),
        .dma_tx_req(dma_tx_req));

    rfd_dma_model #(.RX_N(2), .TX_N(5)) u_dma (.clk(clk), .srst(srst),
        .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req), .dma_rx_ack(dma_rx_ack),
        .dma_rx_eot(dma_rx_eot), .dma_tx_eot(dma_tx_eot));

    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic rfd_ctrl_t cw(input logic en, input logic fl, input logic tx,
            input logic rx);
        rfd_ctrl_t v;
        v = CTRL_RESET;
        v.peripheral_enable = en;
        v.receive_flush = fl;
        v.dma_tx_en = tx;
        v.dma_rx_en = rx;
        return v;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input rfd_ctrl_t v);
        @(posedge clk);
        ctrl_we <= 1'b1;
        ctrl_wdata <= v;
        @(posedge clk);
        ctrl_we <= 1'b0;
        step(1);
    endtask

    // msb first; each bit held one full pace period so exactly one sample lands
    task automatic send(input logic [7:0] b, input int nbits);
        for (int i = 7; i > 7 - nbits; i--) begin
            @(posedge clk);
            rx_bit_valid <= 1'b1;
            rx_bit <= b[i];
            repeat (SDIV - 1) @(posedge clk);
        end
        @(posedge clk);
        rx_bit_valid <= 1'b0;
        step(1);
    endtask

    task automatic wait_ctrl_clear(input int bitpos, output int n);
        n = 0;
        while (ctrl_rdata[bitpos] !== 1'b0 && n < 100) begin
            step(1);
            n++;
        end
        chk("ctrl bit cleared", 16'h0000, {15'h0000, ctrl_rdata[bitpos]});
    endtask

    task automatic pop_byte(input logic [7:0] exp);
        int i;
        i = 0;
        while (rx_avail !== 1'b1 && i < 50) begin
            step(1);
            i++;
        end
        chk("rx_avail", 16'h0001, {15'h0000, rx_avail});
        chk("rx_data", {8'h00, exp}, {8'h00, rx_data});
        @(posedge clk);
        rx_pop <= 1'b1;
        @(posedge clk);
        rx_pop <= 1'b0;
        step(2);
        chk("rx_avail after pop", 16'h0000, {15'h0000, rx_avail});
    endtask

    task automatic t_enable_gate();
        wr(cw(1'b0, 1'b0, 1'b1, 1'b1));
        chk("ctrl with enable off", 16'h0000, ctrl_rdata);
        wr(cw(1'b1, 1'b0, 1'b0, 1'b0));
        chk("ctrl enable on", 16'h0001, ctrl_rdata);
    endtask

    task automatic t_rx_idle_dma();
        send(8'ha5, 8);
        step(3);
        chk("dma_rx_req while disabled", 16'h0000, {15'h0000, dma_rx_req});
        pop_byte(8'ha5);
    endtask

    // software keeps off the fifo until the flush bit reads zero
    task automatic t_flush();
        int n;
        send(8'h11, 8);
        send(8'hf0, 3);
        wr(cw(1'b1, 1'b1, 1'b1, 1'b0));
        chk("flush busy", 16'h0001, {15'h0000, ctrl_rdata.receive_flush});
        chk("rx_avail in flush", 16'h0000, {15'h0000, rx_avail});
        wait_ctrl_clear(FLUSH_BIT, n);
        chk("flush too early", 16'h0001, {15'h0000, n >= 4});
        chk("flush cleared", 16'h0001, {15'h0000, n <= 2 * SDIV + 10});
        chk("ctrl kept", 16'h0201, ctrl_rdata);
        chk("rx_avail after flush", 16'h0000, {15'h0000, rx_avail});
        wr(cw(1'b1, 1'b0, 1'b0, 1'b0));
        send(8'h3c, 8);
        pop_byte(8'h3c);
    endtask

    // only one dma direction enabled at a time
    task automatic t_dma_rx();
        int n;
        send(8'h81, 8);
        send(8'h7e, 8);
        wr(cw(1'b1, 1'b0, 1'b0, 1'b1));
        wait_ctrl_clear(DMA_RX_BIT, n);
        chk("ctrl after rx eot", 16'h0001, ctrl_rdata);
        step(2);
        chk("dma_rx_req after eot", 16'h0000, {15'h0000, dma_rx_req});
        chk("rx_avail drained", 16'h0000, {15'h0000, rx_avail});
    endtask

    task automatic t_dma_tx();
        int n;
        @(posedge clk);
        tx_fifo_ready <= 1'b1;
        wr(cw(1'b1, 1'b0, 1'b1, 1'b0));
        step(1);
        chk("dma_tx_req running", 16'h0001, {15'h0000, dma_tx_req});
        wait_ctrl_clear(DMA_TX_BIT, n);
        chk("ctrl after tx eot", 16'h0001, ctrl_rdata);
        step(2);
        chk("dma_tx_req idle", 16'h0000, {15'h0000, dma_tx_req});
        @(posedge clk);
        tx_fifo_ready <= 1'b0;
        wr(cw(1'b1, 1'b0, 1'b1, 1'b0));
        step(2);
        chk("dma_tx_req no room", 16'h0000, {15'h0000, dma_tx_req});
        @(posedge clk);
        tx_fifo_ready <= 1'b1;
        step(3);
        chk("dma_tx_req room", 16'h0001, {15'h0000, dma_tx_req});
        wait_ctrl_clear(DMA_TX_BIT, n);
    endtask

    task automatic t_enable_off();
        send(8'h55, 8);
        step(3);
        wr(cw(1'b0, 1'b0, 1'b0, 1'b0));
        chk("ctrl enable off", 16'h0000, ctrl_rdata);
        chk("rx_avail enable off", 16'h0000, {15'h0000, rx_avail});
        wr(cw(1'b1, 1'b0, 1'b0, 1'b0));
        step(2);
        chk("fifo emptied by enable off", 16'h0000, {15'h0000, rx_avail});
    endtask

    initial begin
        repeat (7) @(posedge clk);
        #1;
        chk("ctrl in reset", 16'h0000, ctrl_rdata);
        chk("reqs in reset", 16'h0000, {14'h0000, dma_rx_req, dma_tx_req});
        @(posedge clk);
        srst <= 1'b0;
        step(1);
        t_enable_gate();
        t_rx_idle_dma();
        t_flush();
        t_dma_rx();
        t_dma_tx();
        t_enable_off();
        test_done();
    end

    // whole run needs a few hundred cycles
    initial begin
        #200us;
        n_errors++;
        test_done();
    end
endmodule
